// [irq_regs_pkg.sv]
// constants, field layout and state types of the interrupt enable and priority register slice
package irq_regs_pkg;
   // ==========================================================
   // register bus
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 16;
   localparam logic [3:0]  ADR_WAKE_EN = 4'h0;  // wake_irq_enable_5
   localparam logic [3:0]  ADR_PRI0    = 4'h1;  // irq_priority_0
   localparam logic [3:0]  ADR_PRI1    = 4'h2;  // irq_priority_1
   localparam logic [3:0]  ADR_PRI2    = 4'h3;  // irq_priority_2
   localparam logic [3:0]  ADR_PRI3    = 4'h4;  // irq_priority_3
   localparam logic [3:0]  ADR_PRI4    = 4'h5;  // irq_priority_4
   localparam logic [3:0]  ADR_STAT    = 4'h6;  // sticky event status, write one to clear
   localparam logic [3:0]  ADR_MASK    = 4'h7;  // event mask
   // ==========================================================
   // priority fields
   localparam int          LVL_W       = 3;
   localparam logic [2:0]  LVL_RST     = 3'h4;  // level 4 after reset
   localparam logic [2:0]  LVL_OFF     = 3'h0;  // source disabled
   localparam int          NFLD        = 18;
   localparam int          NSRC        = NFLD + 1;
   localparam int          SRC_W       = 5;
   localparam logic [4:0]  WAKE_IDX    = 5'h12;
   localparam int          WAKE_EN_BIT = 0;
   // field i lives in register FLD_REG[i] at bit FLD_LSB[i]; index is the tie order
   localparam logic [3:0]  FLD_REG [NFLD] = '{
      ADR_PRI0, ADR_PRI0, ADR_PRI0, ADR_PRI0,   // ext 0, capture 1, compare 1, timer 1
      ADR_PRI1, ADR_PRI1, ADR_PRI1,             // capture 2, compare 2, timer 2
      ADR_PRI2, ADR_PRI2, ADR_PRI2, ADR_PRI2,   // timer 3, spi fault, spi event, rx
      ADR_PRI3, ADR_PRI3, ADR_PRI3,             // tx, adc done, nonvolatile mem
      ADR_PRI4, ADR_PRI4, ADR_PRI4, ADR_PRI4};  // i2c slave, i2c master, comparator, pin change
   localparam int          FLD_LSB [NFLD] = '{
      0, 4, 8, 12,  4, 8, 12,  0, 4, 8, 12,  0, 4, 12,  0, 4, 8, 12};
   // ==========================================================
   // event status bits
   localparam int          NEVT        = 2;
   localparam int          EVT_WAKE    = 0;     // enabled wake request arrived
   localparam int          EVT_REQ     = 1;     // request to the core raised
   // ==========================================================
   // carriers
   typedef struct packed {
      logic              req;
      logic [2:0]        level;
      logic [SRC_W-1:0]  src;
   } cpu_req_t;

   typedef struct packed {
      logic [NFLD-1:0][LVL_W-1:0] lvl;
      logic                       wake_en;
      logic [NEVT-1:0]            stat;
      logic [NEVT-1:0]            mask;
      logic [DATA_W-1:0]          rdata;
      cpu_req_t                   cpu;
      logic                       wake_seen;
   } regs_state_t;
endpackage

// [irq_level_arbiter.sv]
// combinational picker of the highest pending interrupt level
`timescale 1ns/1ns
module irq_level_arbiter
   import irq_regs_pkg::*;
#(
   parameter int N = NSRC
) (
   input  wire logic [N-1:0]            pend_i,
   input  wire logic [N-1:0][LVL_W-1:0] lvl_i,
   output logic                         valid_o,
   output logic [LVL_W-1:0]             level_o,
   output logic [SRC_W-1:0]             src_o
);
   logic [N-1:0][LVL_W-1:0] eff;

   // ==========================================================
   // per source effective level, zero when idle or disabled
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_eff
         assign eff[g] = pend_i[g] ? lvl_i[g] : LVL_OFF;
      end
   endgenerate

   // ==========================================================
   // strict greater keeps the lowest index on a tie
   always_comb begin
      level_o = LVL_OFF;
      src_o   = '0;
      for (int i = 0; i < N; i++) begin
         if (eff[i] > level_o) begin
            level_o = eff[i];
            src_o   = SRC_W'(i);
         end
      end
      valid_o = (level_o != LVL_OFF);
   end
endmodule // irq_level_arbiter

// [irq_enable_priority_regs.sv]
// interrupt enable and priority register slice with request selection
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Function
// - each priority field is three bits and 111 is level 7, the highest.
// - 001 is level 1, the lowest serviced, and codes between map to levels 2 to 6.
// - 000 disables the source so it never reaches the core.
// - every priority field resets to 100, level 4.
// - bit 0 of the wake enable register gates the wake request and resets to zero.
// - bits 15 to 1 of the wake enable register and reserved priority bits read zero.
// - priority 0 holds timer 1, compare 1, capture 1 and external 0 levels.
// - priority 1 holds timer 2, compare 2 and capture 2, with bits 3-0 reserved.
// - priority 2 holds serial rx, spi event, spi fault and timer 3 levels.
// - priority 3 holds memory, adc done and serial tx, with 11-7 and 3 reserved.
// - priority 4 holds pin change, comparator, i2c master and i2c slave levels.
module irq_enable_priority_regs
   import irq_regs_pkg::*;
#(
   parameter logic [2:0] WAKE_LEVEL = LVL_RST
) (
   input  wire logic              mclk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic [NFLD-1:0]   src_pend_i,
   input  wire logic              wake_pend_i,
   output cpu_req_t               cpu_o,
   output logic                   irq_o
);
   regs_state_t             st_ff;
   regs_state_t             nxt_st;
   logic [NSRC-1:0]         arb_pend;
   logic [NSRC-1:0][2:0]    arb_lvl;
   logic                    arb_valid;
   logic [LVL_W-1:0]        arb_level;
   logic [SRC_W-1:0]        arb_src;
   logic [NEVT-1:0]         evt;

   // ==========================================================
   // arbiter inputs: wake source joins at a fixed level behind its enable
   assign arb_pend = {wake_pend_i & st_ff.wake_en, src_pend_i};
   assign arb_lvl  = {WAKE_LEVEL, st_ff.lvl};

   irq_level_arbiter #(
      .N       (NSRC)
   ) u_arb (
      .pend_i  (arb_pend),
      .lvl_i   (arb_lvl),
      .valid_o (arb_valid),
      .level_o (arb_level),
      .src_o   (arb_src)
   );

   // ==========================================================
   // events that set sticky status bits
   always_comb begin
      evt           = '0;
      evt[EVT_WAKE] = arb_pend[WAKE_IDX] & ~st_ff.wake_seen;
      evt[EVT_REQ]  = arb_valid & ~st_ff.cpu.req;
   end

   // ==========================================================
   // next state: register writes, read data, status, request to core
   always_comb begin
      nxt_st = st_ff;
      if (ce_i) begin
         nxt_st.rdata = '0;
         // read data stand only in the cycle after the strobe
         if (rd_i) begin
            for (int i = 0; i < NFLD; i++) begin
               if (addr_i == FLD_REG[i]) begin
                  nxt_st.rdata[FLD_LSB[i] +: LVL_W] = st_ff.lvl[i];
               end
            end
            case (addr_i)
               ADR_WAKE_EN: nxt_st.rdata[WAKE_EN_BIT] = st_ff.wake_en;
               ADR_STAT:    nxt_st.rdata[NEVT-1:0]    = st_ff.stat;
               ADR_MASK:    nxt_st.rdata[NEVT-1:0]    = st_ff.mask;
               default:     ;
            endcase
         end
         // writes touch only implemented bits
         if (wr_i) begin
            for (int i = 0; i < NFLD; i++) begin
               if (addr_i == FLD_REG[i]) begin
                  nxt_st.lvl[i] = wdata_i[FLD_LSB[i] +: LVL_W];
               end
            end
            case (addr_i)
               ADR_WAKE_EN: nxt_st.wake_en = wdata_i[WAKE_EN_BIT];
               ADR_STAT:    nxt_st.stat    = st_ff.stat & ~wdata_i[NEVT-1:0];
               ADR_MASK:    nxt_st.mask    = wdata_i[NEVT-1:0];
               default:     ;
            endcase
         end
         // a set in the clearing cycle wins
         nxt_st.stat      = nxt_st.stat | evt;
         nxt_st.wake_seen = arb_pend[WAKE_IDX];
         // registered request to the core
         nxt_st.cpu.req   = arb_valid;
         nxt_st.cpu.level = arb_level;
         nxt_st.cpu.src   = arb_src;
      end
   end

   // ==========================================================
   // state register with synchronous reset
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_ff           <= '0;
         st_ff.lvl       <= {NFLD{LVL_RST}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign rdata_o = st_ff.rdata;
   assign cpu_o   = st_ff.cpu;
   assign irq_o   = |(st_ff.stat & st_ff.mask);

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   a_reset_level: assert property (
      $past(sys_rst_i) |-> (st_ff.lvl[0] == LVL_RST) && (st_ff.lvl[NFLD-1] == LVL_RST))
      else $error("priority field not level 4 after reset");

   // the registered request reflects the pending inputs of the previous edge
   a_zero_blocks: assert property (
      $past(ce_i) && cpu_o.req |-> (cpu_o.level != LVL_OFF) && $past(arb_pend[arb_src]))
      else $error("request made at level zero");

   a_highest_wins: assert property (
      ce_i && src_pend_i[0] |-> arb_level >= st_ff.lvl[0])
      else $error("pending source above presented level");

   a_low_served: assert property (
      ce_i && src_pend_i[3] && st_ff.lvl[3] == 3'h1 |=> cpu_o.req ##0 cpu_o.level >= 3'h1)
      else $error("level one source not served");

   a_wake_gate: assert property (
      !st_ff.wake_en |-> !arb_valid || arb_src != WAKE_IDX)
      else $error("wake request passed while disabled");

   a_resv_zero: assert property (
      $past(ce_i && rd_i && addr_i == ADR_WAKE_EN) |-> rdata_o[DATA_W-1:1] == '0)
      else $error("reserved wake enable bits read nonzero");

   a_reg0_layout: assert property (
      ce_i && wr_i && addr_i == ADR_PRI0 |=> st_ff.lvl[3] == $past(wdata_i[14:12])
         && st_ff.lvl[0] == $past(wdata_i[2:0]))
      else $error("priority 0 field placement wrong");

   a_reg1_resv: assert property (
      $past(ce_i && rd_i && addr_i == ADR_PRI1) |-> rdata_o[3:0] == 4'h0)
      else $error("priority 1 reserved bits nonzero");

   a_reg2_layout: assert property (
      ce_i && wr_i && addr_i == ADR_PRI2 |=> st_ff.lvl[7] == $past(wdata_i[2:0])
         && st_ff.lvl[10] == $past(wdata_i[14:12]))
      else $error("priority 2 field placement wrong");

   a_reg3_resv: assert property (
      $past(ce_i && rd_i && addr_i == ADR_PRI3) |-> rdata_o[11:7] == 5'h00 && !rdata_o[3])
      else $error("priority 3 reserved bits nonzero");

   a_reg4_layout: assert property (
      ce_i && wr_i && addr_i == ADR_PRI4 |=> st_ff.lvl[17] == $past(wdata_i[14:12])
         && st_ff.lvl[14] == $past(wdata_i[2:0]))
      else $error("priority 4 field placement wrong");

   a_req_follows: assert property (
      ce_i |=> cpu_o.req == $past(arb_valid) && cpu_o.level == $past(arb_level))
      else $error("core request does not follow selection");

   a_status_set: assert property (
      ce_i && evt[EVT_REQ] |=> st_ff.stat[EVT_REQ])
      else $error("event lost against clear");

   a_wake_seen: assert property (
      ce_i && evt[EVT_WAKE] |=> st_ff.stat[EVT_WAKE])
      else $error("wake event not recorded");

   a_clear_works: assert property (
      ce_i && wr_i && addr_i == ADR_STAT && wdata_i[EVT_REQ] && !evt[EVT_REQ]
         |=> !st_ff.stat[EVT_REQ])
      else $error("status bit not cleared by write of one");

   a_irq_raise: assert property (
      st_ff.stat[EVT_REQ] && st_ff.mask[EVT_REQ] |-> irq_o)
      else $error("unmasked status bit without interrupt");

   // ==========================================================
   // bus side checks: freeze, idle read data, unmapped index
   a_ce_freeze: assert property (
      !ce_i |=> $stable(st_ff))
      else $error("state moved with clock enable low");

   a_rdata_idle: assert property (
      $past(ce_i) && !$past(rd_i) |-> rdata_o == '0)
      else $error("read data present without a read");

   a_unmapped_read: assert property (
      $past(ce_i && rd_i && addr_i > ADR_MASK) |-> rdata_o == '0)
      else $error("unmapped index read nonzero");

   // ==========================================================
   // field placement and reserved bits of the remaining registers
   a_pri0_resv: assert property (
      $past(ce_i && rd_i && addr_i == ADR_PRI0)
         |-> !rdata_o[15] && !rdata_o[11] && !rdata_o[7] && !rdata_o[3])
      else $error("priority 0 reserved bits nonzero");

   a_reg1_layout: assert property (
      ce_i && wr_i && addr_i == ADR_PRI1 |=> st_ff.lvl[6] == $past(wdata_i[14:12])
         && st_ff.lvl[4] == $past(wdata_i[6:4]))
      else $error("priority 1 field placement wrong");

   a_reg3_layout: assert property (
      ce_i && wr_i && addr_i == ADR_PRI3 |=> st_ff.lvl[13] == $past(wdata_i[14:12])
         && st_ff.lvl[12] == $past(wdata_i[6:4]) && st_ff.lvl[11] == $past(wdata_i[2:0]))
      else $error("priority 3 field placement wrong");

   a_wake_write: assert property (
      ce_i && wr_i && addr_i == ADR_WAKE_EN |=> st_ff.wake_en == $past(wdata_i[WAKE_EN_BIT]))
      else $error("wake enable bit not written");

   // ==========================================================
   // request levels: wake level, top level, disabled source
   a_wake_level: assert property (
      cpu_o.req && cpu_o.src == WAKE_IDX |-> cpu_o.level == WAKE_LEVEL)
      else $error("wake request at wrong level");

   a_top_level: assert property (
      $past(ce_i) && $past(src_pend_i[3]) && $past(st_ff.lvl[3]) == 3'h7
         |-> cpu_o.req && cpu_o.level == 3'h7)
      else $error("level seven source not presented at level seven");

   a_off_silent: assert property (
      $past(ce_i) && $past(st_ff.lvl[0]) == LVL_OFF && cpu_o.req |-> cpu_o.src != 5'h00)
      else $error("disabled source reached the core");
endmodule // irq_enable_priority_regs

// [cpu_core_model.sv]
// behavioural core that takes the winning request presented by the register slice
`timescale 1ns/1ns
module cpu_core_model
   import irq_regs_pkg::*;
(
   input  wire logic     mclk_i,
   input  wire logic     sys_rst_i,
   input  wire cpu_req_t req_i,
   output cpu_req_t      seen_o
);
   // ==========================================================
   // take a request on every edge it is raised, keep the last one taken
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         seen_o <= '0;
      end else if (req_i.req) begin
         seen_o <= req_i;
      end
   end
endmodule // cpu_core_model

// [irq_enable_priority_regs_tb.sv]
// self-checking bench of the interrupt enable and priority register slice
`timescale 1ns/1ns
module irq_enable_priority_regs_tb import irq_regs_pkg::*; ();
   // ==========================================================
   // signals
   logic              mclk_i      = 1'b0;
   logic              sys_rst_i   = 1'b1;
   logic              ce_i        = 1'b1;
   logic [ADDR_W-1:0] addr_i      = '0;
   logic [DATA_W-1:0] wdata_i     = '0;
   logic              wr_i        = 1'b0;
   logic              rd_i        = 1'b0;
   logic [NFLD-1:0]   src_pend_i  = '0;
   logic              wake_pend_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   cpu_req_t          cpu_o;
   cpu_req_t          seen;
   logic              irq_o;
   int                miscompares = 0;
   int                comparisons = 0;
   // register number and field offset of each source, in tie order
   localparam int SRC_REG [NFLD] = '{0,0,0,0, 1,1,1, 2,2,2,2, 3,3,3, 4,4,4,4};
   localparam int SRC_LSB [NFLD] = '{0,4,8,12, 4,8,12, 0,4,8,12, 0,4,12, 0,4,8,12};
   // implemented bits of wake enable and priority 0..4
   localparam logic [15:0] RW_MASK [6] = '{16'h0001, 16'h7777, 16'h7770,
                                           16'h7777, 16'h7077, 16'h7777};
   irq_enable_priority_regs uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .src_pend_i(src_pend_i), .wake_pend_i(wake_pend_i), .cpu_o(cpu_o), .irq_o(irq_o));
   cpu_core_model core_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(cpu_o),
      .seen_o(seen));
   // ==========================================================
   // clock, reset and watchdog
   initial begin
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
   end
   initial begin
      #20000;
      miscompares++;
      final_report();
   end
   // ==========================================================
   // compare and bus tasks
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_req(input cpu_req_t got, input cpu_req_t exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t request %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 chk16(rdata_o, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task automatic set_all(input logic [15:0] d);
      for (int k = 0; k < 5; k++) reg_wr(ADR_PRI0 + 4'(k), d);
   endtask
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================================
   // test sequence
   initial begin
      repeat (12) @(posedge mclk_i);
      for (int k = 0; k < 6; k++) begin
         reg_rd(4'(k), (k == 0) ? 16'h0000 : (16'h4444 & RW_MASK[k]));
      end
      for (int k = 0; k < 6; k++) begin
         reg_wr(4'(k), 16'hFFFF);
         reg_rd(4'(k), RW_MASK[k]);
      end
      reg_wr(4'h8, 16'hFFFF);
      reg_rd(4'h8, 16'h0000);
      // a write with the clock enable low is dropped
      @(posedge mclk_i);
      ce_i <= 1'b0;
      reg_wr(ADR_PRI0, 16'h0000);
      ce_i <= 1'b1;
      reg_rd(ADR_PRI0, 16'h7777);
      // all sources pending at level 1: lowest index wins, then each field raised to 7
      set_all(16'h1111);
      src_pend_i <= '1;
      settle();
      chk_req(cpu_o, cpu_req_t'{1'b1, 3'h1, 5'h00});
      for (int i = 0; i < NFLD; i++) begin
         reg_wr(ADR_PRI0 + 4'(SRC_REG[i]), 16'h1111 | (16'h0006 << SRC_LSB[i]));
         settle();
         chk_req(cpu_o, cpu_req_t'{1'b1, 3'h7, 5'(i)});
         reg_wr(ADR_PRI0 + 4'(SRC_REG[i]), 16'h1111);
      end
      set_all(16'h0000);
      settle();
      chk_req(cpu_o, cpu_req_t'{1'b0, 3'h0, 5'h00});
      // each level beats the one just below it
      for (int k = 2; k < 8; k++) begin
         reg_wr(ADR_PRI0, 16'(k * 4096 + k - 1));
         settle();
         chk_req(cpu_o, cpu_req_t'{1'b1, 3'(k), 5'h03});
      end
      reg_wr(ADR_PRI0, 16'h0000);
      reg_wr(ADR_WAKE_EN, 16'h0000);
      wake_pend_i <= 1'b1;
      settle();
      chk_req(cpu_o, cpu_req_t'{1'b0, 3'h0, 5'h00});
      reg_wr(ADR_WAKE_EN, 16'h0001);
      settle();
      chk_req(cpu_o, cpu_req_t'{1'b1, LVL_RST, WAKE_IDX});
      // sticky status, mask and level interrupt
      reg_rd(ADR_STAT, 16'h0003);
      chk16({15'h0000, irq_o}, 16'h0000);
      reg_wr(ADR_MASK, 16'h0002);
      settle();
      chk16({15'h0000, irq_o}, 16'h0001);
      wake_pend_i <= 1'b0;
      src_pend_i  <= '0;
      settle();
      reg_wr(ADR_STAT, 16'h0003);
      settle();
      reg_rd(ADR_STAT, 16'h0000);
      chk16({15'h0000, irq_o}, 16'h0000);
      chk_req(seen, cpu_req_t'{1'b1, LVL_RST, WAKE_IDX});
      final_report();
   end
endmodule // irq_enable_priority_regs_tb
